//--- flight_computer_end.sv
/*
  Flight computer end: sends a coded word to a stage, checks the returned
  complement, then issues execute when its user says the time has come.
  Assumes user strobes are synchronous one-cycle pulses on I_CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none
module flight_computer_end
  import stage_selector_pkg::*;
(
  // Clock and reset
  input  wire logic               I_CLOCK,
  input  wire logic               I_RESET,
  // Link toward the stage
  stage_link_if.computer          LINK,
  // Command request
  input  wire logic               I_START,
  input  wire logic [STAGE_W-1:0] I_STAGE,
  input  wire logic [WORD_W-1:0]  I_CODE,
  input  wire logic               I_FIRE,
  input  wire logic               I_EMERGENCY,
  // Status
  output logic                    O_BUSY,
  output logic                    O_READY,
  output logic                    O_DONE,
  output logic                    O_VERIFY_FAIL
);

  typedef enum logic [2:0] {IDLE, SEND, WAIT, READY, FIRE} cstate_type;

  cstate_type         state_r;
  cstate_type         state_nxt;
  logic [STAGE_W-1:0] stage_r;
  logic [WORD_W-1:0]  word_r;
  logic [TMR_W-1:0]   tmr_r;
  logic               done_r;
  logic               fail_r;
  logic               emerg_r;
  logic               echo_ok;
  logic               timeout;

  // Echo must be the exact complement of what was sent
  assign echo_ok = LINK.echo_valid && (LINK.echo == ~word_r);
  assign timeout = (tmr_r == TMR_W'(ECHO_TIMEOUT_CYC));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IDLE:  if (I_START) state_nxt = SEND;
      SEND:  state_nxt = WAIT;
      WAIT: begin
        if (LINK.echo_valid) state_nxt = echo_ok ? READY : IDLE;
        else if (timeout)    state_nxt = IDLE;
      end
      READY: if (I_FIRE) state_nxt = FIRE;
      FIRE:  state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) state_r <= IDLE;
    else         state_r <= state_nxt;
  end

  // Captured request
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      stage_r <= FIRST_STAGE;
      word_r  <= WORD_RESET;
    end else if (state_r == IDLE && I_START) begin
      stage_r <= I_STAGE;
      word_r  <= I_CODE;
    end
  end

  // Echo wait timer
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET)              tmr_r <= '0;
    else if (state_r == WAIT) tmr_r <= tmr_r + TMR_W'(1);
    else                      tmr_r <= '0;
  end

  // Completion and failure pulses
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      done_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      done_r <= (state_r == FIRE);
      fail_r <= (state_r == WAIT) && ((LINK.echo_valid && !echo_ok) || (!LINK.echo_valid && timeout));
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) emerg_r <= 1'b0;
    else         emerg_r <= I_EMERGENCY;
  end

  assign LINK.load       = (state_r == SEND);
  assign LINK.exec       = (state_r == FIRE);
  assign LINK.stage_addr = stage_r;
  assign LINK.word       = word_r;
  assign LINK.emergency  = emerg_r;

  assign O_BUSY        = (state_r != IDLE);
  assign O_READY       = (state_r == READY);
  assign O_DONE        = done_r;
  assign O_VERIFY_FAIL = fail_r;

endmodule
`default_nettype wire

//--- stage_command_switch_selector_tb.sv
/*
  Testbench joining the flight computer end and the stage selector.
  Assumes one 20 MHz clock and the default stage address on the selector.
*/
`timescale 1ns/1ps
`default_nettype none
module stage_command_switch_selector_tb;
  import stage_selector_pkg::*;
  logic             clk, rst, start, fire, emerg, unl;
  logic [1:0]       stg;
  logic [7:0]       code, rnd, held;
  logic [9:0]       lat;
  int               err_count, n_compared;
  wire logic        busy, rdy, done, vfail, allr, shut, armed, rej;
  wire logic [111:0] chan;
  wire logic [9:0]  cmd;
  wire logic [7:0]  whold;

  stage_link_if lnk ();
  flight_computer_end i_flight_computer_end (.I_CLOCK(clk), .I_RESET(rst), .LINK(lnk.computer),
    .I_START(start), .I_STAGE(stg), .I_CODE(code), .I_FIRE(fire), .I_EMERGENCY(emerg),
    .O_BUSY(busy), .O_READY(rdy), .O_DONE(done), .O_VERIFY_FAIL(vfail));
  stage_switch_selector i_stage_switch_selector (.I_CLOCK(clk), .I_RESET(rst), .LINK(lnk.selector),
    .I_UNLATCH(unl), .O_ALL_RESET(allr), .O_CHANNEL(chan), .O_STAGE_CMD(cmd),
    .O_ENGINE_SHUTDOWN(shut), .O_WORD_HELD(whold), .O_ARMED(armed), .O_REJECT(rej));
  stage_link_assertions i_stage_link_assertions (.I_CLOCK(clk), .I_RESET(rst), .load(lnk.load),
    .exec(lnk.exec), .stage_addr(lnk.stage_addr), .word(lnk.word), .emergency(lnk.emergency),
    .echo(lnk.echo), .echo_valid(lnk.echo_valid));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic [111:0] chan_exp(input logic [7:0] c);
    return (c < 8'h70) ? (112'h1 << c) : 112'h0;
  endfunction

  task automatic chk(input logic [111:0] seen, input logic [111:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_ok(input int k, input int lim);
    if (k >= lim) begin
      chk(112'h0, 112'h1);
      end_of_test();
    end
  endtask

  // One command: load, verify, then fire if verified
  task automatic run(input logic [1:0] st, input logic [7:0] cd);
    int   k;
    logic ok;
    ok = (st == FIRST_STAGE);
    @(posedge clk);
    start <= 1'b1;
    stg   <= st;
    code  <= cd;
    @(posedge clk);
    start <= 1'b0;
    for (k = 0; k < 40 && rdy !== 1'b1 && vfail !== 1'b1; k++) @(negedge clk);
    wait_ok(k, 40);
    chk(k, ok ? 3 : ECHO_TIMEOUT_CYC + 3);
    chk(rdy, ok);
    chk(vfail, !ok);
    chk(busy, ok);
    chk(whold, ok ? cd : held);
    if (!ok) return;
    held = cd;
    chk(lnk.echo, 8'(~cd));
    chk(armed, 1'b1);
    chk(chan, 112'h0);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    for (k = 0; k < 10 && done !== 1'b1; k++) @(negedge clk);
    wait_ok(k, 10);
    chk(k, 2);
    chk(busy, 1'b0);
    chk(chan, chan_exp(cd));
    chk(rej, cd >= 8'h70);
    for (int j = 0; j < NUM_FUNC; j++) if (cd == {1'b0, FUNC_CHAN[j]}) lat[j] = 1'b1;
    @(negedge clk);
    chk(chan, 112'h0);
    chk(cmd, lat);
    chk(allr, lat == 10'h000);
  endtask

  task automatic unlatch();
    @(posedge clk);
    unl <= 1'b1;
    @(posedge clk);
    unl <= 1'b0;
    @(negedge clk);
    lat = 10'h000;
    chk(cmd, lat);
    chk(allr, 1'b1);
    chk(shut, 1'b0);
  endtask

  initial begin
    rst = 1'b1; start = 1'b0; fire = 1'b0; emerg = 1'b0; unl = 1'b0;
    stg = 2'h0; code = 8'h00; rnd = 8'h49; held = 8'h00; lat = 10'h000;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(allr, 1'b1);
    chk(cmd, 10'h000);
    for (int i = 1; i <= NUM_FUNC; i++) run(FIRST_STAGE, 8'(i));
    run(FIRST_STAGE, 8'h00);
    run(FIRST_STAGE, 8'h6F);
    run(FIRST_STAGE, 8'h70);
    run(2'h1, 8'h03);
    unlatch();
    for (int i = 0; i < 12; i++) begin
      rnd = next_rand(rnd);
      run(rnd[7] ? rnd[1:0] : FIRST_STAGE, rnd % 8'h70);
    end
    // Emergency bypasses the channel path
    @(posedge clk);
    emerg <= 1'b1;
    @(negedge clk);
    chk(shut, 1'b0);
    repeat (2) @(negedge clk);
    chk(shut, 1'b1);
    chk(chan, 112'h0);
    chk(cmd, lat);
    @(posedge clk);
    emerg <= 1'b0;
    unlatch();
    end_of_test();
  end
endmodule
`default_nettype wire

//--- stage_link_assertions.sv
/*
  Checker for the link between the flight computer end and the stage selector.
  Assumes it is instantiated beside the link interface and shares its clock.
*/
`timescale 1ns/1ps
`default_nettype none
module stage_link_assertions
  import stage_selector_pkg::*;
#(
  parameter logic [STAGE_W-1:0] STAGE_ID = FIRST_STAGE
)
(
  // Clock and reset
  input wire logic               I_CLOCK,
  input wire logic               I_RESET,
  // Computer to selector
  input wire logic               load,
  input wire logic               exec,
  input wire logic [STAGE_W-1:0] stage_addr,
  input wire logic [WORD_W-1:0]  word,
  input wire logic               emergency,
  // Selector to computer
  input wire logic [WORD_W-1:0]  echo,
  input wire logic               echo_valid
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  wire logic hit = load && stage_addr == STAGE_ID;

  a_echo_complement:
    assert property (hit |=> echo_valid && echo == ~$past(word)) else $error("echo is not the complement");
  a_foreign_quiet:
    assert property (load && !hit |=> !echo_valid && $stable(echo)) else $error("foreign word answered");
  a_echo_held:
    assert property (!hit |=> $stable(echo)) else $error("echo changed without a load");
  a_valid_cause:
    assert property (echo_valid |-> $past(hit)) else $error("echo valid without a load");
  a_valid_pulse:
    assert property (echo_valid |=> !echo_valid) else $error("echo valid longer than one cycle");
  a_load_pulse:
    assert property (load |=> !load) else $error("load longer than one cycle");
  a_exec_verified:
    assert property (exec |-> echo == ~word) else $error("execute after failed verify");
  a_exec_late:
    assert property (exec |-> !load && !$past(load)) else $error("execute too soon after load");
  a_emerg_no_echo:
    assert property (emergency && !hit |=> !echo_valid) else $error("emergency answered on the echo path");
endmodule
`default_nettype wire

//--- stage_link_if.sv
/*
  Link between the flight_computer end and the stage switch selector end.
  Assumes both ends share one clock; each signal has one driving modport.
*/
`timescale 1ns/1ps
`default_nettype none
interface stage_link_if;
  import stage_selector_pkg::*;

  // Computer to selector
  logic               load;
  logic               exec;
  logic [STAGE_W-1:0] stage_addr;
  logic [WORD_W-1:0]  word;
  logic               emergency;

  // Selector to computer
  logic [WORD_W-1:0]  echo;
  logic               echo_valid;

  modport computer (
    output load,
    output exec,
    output stage_addr,
    output word,
    output emergency,
    input  echo,
    input  echo_valid
  );

  modport selector (
    input  load,
    input  exec,
    input  stage_addr,
    input  word,
    input  emergency,
    output echo,
    output echo_valid
  );
endinterface
`default_nettype wire

//--- stage_selector_pkg.sv
/*
  Constants shared by both ends of the stage command link: word widths, stage
  addressing, channel count, command-function channel map and link timing.
  Assumes a single 20 MHz clock drives both ends and the interface between them.
*/
// How it works
// - Eight-bit coded word selects one output switch.
// - Word addressed here is stored and held.
// - Complement of stored word is sent back.
// - Channel fires only on a later execute.
// - At least 112 decoded output channels exist.
// - Computer times commands; ten functions are mapped.
// - Emergency command shuts all engines, bypassing selector; code sets shutdown in selector, apart from channel path.
// - Selector output latches that function's own element.
// - Latched element drives its stage command output.
// - One latch per function; ground unlatch clears.
// - All-reset shown only when every latch clear.
package stage_selector_pkg;

  // Coded word and addressing
  localparam int          WORD_W       = 8;
  localparam int          STAGE_W      = 2;
  localparam logic [1:0]  FIRST_STAGE  = 2'h0;

  // Decoded output channels
  localparam int          NUM_CHANNELS = 112;
  localparam int          CHAN_W       = 7;
  localparam logic [7:0]  CHAN_LIMIT   = 8'h70;

  // Command functions held by the distributor, one latch each
  localparam int          NUM_FUNC     = 10;
  localparam logic [6:0]  FUNC_CHAN [0:NUM_FUNC-1] = '{
    7'h01,  // Telemetry calibration on
    7'h02,  // Telemetry calibration off
    7'h03,  // Helium flow control valve 2 open
    7'h04,  // Helium flow control valve 3 open
    7'h05,  // Helium flow control valve 4 open
    7'h06,  // Center engine cutoff enable
    7'h07,  // Outboard engine cutoff enable
    7'h08,  // Arm bridgewire_firing_unit, retro and separation
    7'h09,  // Fire bridgewire_firing_unit, retro and separation
    7'h0A   // Measurement switchover
  };

  // Link timing
  localparam int          CLOCK_HZ        = 20_000_000;
  localparam int          ECHO_TIMEOUT_NS = 1000;
  localparam int          ECHO_TIMEOUT_CYC = (ECHO_TIMEOUT_NS / 50 < 1) ? 1 :
                                             ECHO_TIMEOUT_NS / (1_000_000_000 / CLOCK_HZ);
  localparam int          TMR_W           = 8;

  // Reset values
  localparam logic [7:0]  WORD_RESET   = 8'h00;

endpackage

//--- stage_switch_selector.sv
/*
  Stage switch selector with its command distributor. A coded word addressed
  to this stage is stored and echoed as its complement; a later execute fires
  one of the decoded channels for one cycle. Channels mapped to command
  functions set latches that hold their stage commands until ground unlatch.
  Codes from the channel count upward are refused with a one-cycle reject
  pulse, as is an execute with no stored word waiting for it.
  Assumes the link and the ground unlatch are synchronous to I_CLOCK, and
  that the computer sends execute only after it has checked the echo.
*/
`timescale 1ns/1ps
`default_nettype none
module stage_switch_selector
  import stage_selector_pkg::*;
#(
  parameter logic [STAGE_W-1:0] STAGE_ID = FIRST_STAGE
)
(
  // Clock and reset
  input  wire logic                    I_CLOCK,
  input  wire logic                    I_RESET,

  // Link from the flight computer
  stage_link_if.selector               LINK,

  // Ground support equipment
  input  wire logic                    I_UNLATCH,
  output logic                         O_ALL_RESET,

  // Decoded channels, one-cycle pulses
  output logic [NUM_CHANNELS-1:0]      O_CHANNEL,

  // Latched stage commands
  output logic [NUM_FUNC-1:0]          O_STAGE_CMD,
  output logic                         O_ENGINE_SHUTDOWN,

  // Selector state
  output logic [WORD_W-1:0]            O_WORD_HELD,
  output logic                         O_ARMED,
  output logic                         O_REJECT
);

  // Storage register and echo
  logic [WORD_W-1:0]       word_r;
  logic                    armed_r;
  logic [WORD_W-1:0]       echo_r;
  logic                    echo_valid_r;

  // Channel decode
  logic                    addr_hit;
  logic                    take_load;
  logic                    take_exec;
  logic                    code_ok;
  logic                    fire_ok;
  logic [NUM_CHANNELS-1:0] channel_r;
  logic [NUM_CHANNELS-1:0] channel_nxt;
  logic                    reject_r;

  // Distributor
  logic [NUM_FUNC-1:0]     latch_r;
  logic [NUM_FUNC-1:0]     latch_nxt;
  logic [NUM_FUNC-1:0]     func_set;
  logic [NUM_FUNC:0]       clear_chain;
  logic                    all_reset_r;
  logic                    shutdown_r;

  // Address match: words for another stage leave everything alone
  // An execute riding with a load is dropped: the word must be stored first
  assign addr_hit  = (LINK.stage_addr == STAGE_ID);
  assign take_load = LINK.load && addr_hit;
  assign take_exec = LINK.exec && addr_hit && !LINK.load;

  // Codes at or above the channel count have no switch behind them
  assign code_ok = (word_r < CHAN_LIMIT);
  assign fire_ok = take_exec && armed_r && code_ok;

  // Storage register, held until the next word for this stage
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      word_r <= WORD_RESET;
    end else if (take_load) begin
      word_r <= LINK.word;
    end
  end

  // Armed from storing until one execute consumes the word, so a repeated
  // execute cannot pulse the same channel twice
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      armed_r <= 1'b0;
    end else if (take_load) begin
      armed_r <= 1'b1;
    end else if (take_exec) begin
      armed_r <= 1'b0;
    end
  end

  // Complement of the stored word, returned the cycle after the load
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      echo_r <= WORD_RESET;
    end else if (take_load) begin
      echo_r <= ~LINK.word;
    end
  end

  // Echo qualifier, one pulse for each accepted load
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      echo_valid_r <= 1'b0;
    end else begin
      echo_valid_r <= take_load;
    end
  end

  assign LINK.echo       = echo_r;
  assign LINK.echo_valid = echo_valid_r;

  // Channel decode: one switch, only on execute of an armed word
  always_comb begin
    channel_nxt = '0;
    if (fire_ok) begin
      channel_nxt[CHAN_W'(word_r)] = 1'b1;
    end
  end

  // Registered, so each channel pulse is clean and lasts one cycle
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      channel_r <= '0;
    end else begin
      channel_r <= channel_nxt;
    end
  end

  // Execute with nothing armed, or of an unmapped code, is refused
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      reject_r <= 1'b0;
    end else begin
      reject_r <= take_exec && !fire_ok;
    end
  end

  // Distributor: one latch per command function
  assign clear_chain[0] = 1'b1;

  generate
    for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
      // Only the channel assigned to this function sets its latch
      assign func_set[f] = channel_r[FUNC_CHAN[f]];

      always_comb begin
        if (func_set[f]) begin
          latch_nxt[f] = 1'b1;
        end else if (I_UNLATCH) begin
          latch_nxt[f] = 1'b0;
        end else begin
          latch_nxt[f] = latch_r[f];
        end
      end

      // Series chain: each cleared latch passes the all-clear on
      assign clear_chain[f+1] = clear_chain[f] & ~latch_nxt[f];
    end
  endgenerate

  // Set outranks unlatch in the same cycle, so no command is lost
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      latch_r <= '0;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // Series chain of cleared states
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      all_reset_r <= 1'b1;
    end else begin
      all_reset_r <= clear_chain[NUM_FUNC];
    end
  end

  // Emergency shutdown, apart from the channel path; a standing emergency
  // outranks unlatch, so the shutdown cannot be cleared while still commanded
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      shutdown_r <= 1'b0;
    end else if (LINK.emergency) begin
      shutdown_r <= 1'b1;
    end else if (I_UNLATCH) begin
      shutdown_r <= 1'b0;
    end
  end

  // Outputs
  assign O_CHANNEL         = channel_r;
  assign O_STAGE_CMD       = latch_r;
  assign O_ALL_RESET       = all_reset_r;
  assign O_ENGINE_SHUTDOWN = shutdown_r;
  assign O_WORD_HELD       = word_r;
  assign O_ARMED           = armed_r;
  assign O_REJECT          = reject_r;

endmodule
`default_nettype wire
